// ==== inc/spq_regs.vh ====
// Constants shared by the serial port queue and fault logic.
`ifndef SPQ_REGS_VH
`define SPQ_REGS_VH

// Rate select codes for the four bit-rate divisors.
`define SPQ_RATE_DIV2     2'h0
`define SPQ_RATE_DIV8     2'h1
`define SPQ_RATE_DIV32    2'h2
`define SPQ_RATE_DIV128   2'h3

// Terminal counts of the half-bit divider (half period minus one bus cycle).
`define SPQ_HALF_DIV2     6'h00
`define SPQ_HALF_DIV8     6'h03
`define SPQ_HALF_DIV32    6'h0F
`define SPQ_HALF_DIV128   6'h3F
`define SPQ_HALF_ZERO     6'h00
`define SPQ_HALF_STEP     6'h01

// Edge counter: sixteen clock edges make one eight-bit transfer.
`define SPQ_EDGE_ZERO     4'h0
`define SPQ_EDGE_STEP     4'h1
`define SPQ_EDGE_LAST     4'hF

// Index of the capture strobe that checks for an overrun.
`define SPQ_OVR_CAPTURE   3'h6

// Reset value of byte-wide registers.
`define SPQ_BYTE_ZERO     8'h00

`endif

// ==== logic/spq_clkdiv.v ====
// Free-running half-bit tick generator for the master serial clock.
`timescale 1ns/1ns
`include "spq_regs.vh"

module spq_clkdiv (
    input  wire       ref_clk_i,  // Bus clock.
    input  wire       reset_i,    // Synchronous reset, active high.
    input  wire       run_i,      // Divider runs only while this is high.
    input  wire [1:0] rate_i,     // Rate select field.
    output reg        tick_o      // One-cycle pulse every half bit period.
);

    reg  [5:0] count;             // Bus cycles elapsed in this half period.

    // Maps the rate select field to the terminal count of a half period.
    function [5:0] spq_half_limit;
        input [1:0] rate;
        begin
            case (rate)
                `SPQ_RATE_DIV2:  spq_half_limit = `SPQ_HALF_DIV2;
                `SPQ_RATE_DIV8:  spq_half_limit = `SPQ_HALF_DIV8;
                `SPQ_RATE_DIV32: spq_half_limit = `SPQ_HALF_DIV32;
                default:         spq_half_limit = `SPQ_HALF_DIV128;
            endcase
        end
    endfunction

    // The counter is held at zero when stopped, which saves power in slave
    // mode and lets the first tick come no later than one half period on.
    always @(posedge ref_clk_i) begin
        if (reset_i || !run_i) begin
            count  <= `SPQ_HALF_ZERO;
            tick_o <= 1'b0;
        end else if (count >= spq_half_limit(rate_i)) begin
            count  <= `SPQ_HALF_ZERO;
            tick_o <= 1'b1;
        end else begin
            count  <= count + `SPQ_HALF_STEP;
            tick_o <= 1'b0;
        end
    end

endmodule

// ==== logic/spq_core.v ====
// Serial port core with transmit queue, overrun and select fault handling.
`timescale 1ns/1ns
`include "spq_regs.vh"

module spq_core (
    input  wire       ref_clk_i,             // Bus clock, 125 MHz.
    input  wire       reset_i,               // Synchronous reset, active high.
    input  wire       ctrl_wr_i,             // Control register write strobe.
    input  wire       ctrl_enable_i,         // Module enable value to write.
    input  wire       ctrl_master_i,         // Master select value to write.
    input  wire       ctrl_cpol_i,           // Clock polarity value to write.
    input  wire       ctrl_clock_phase_bit_i,           // Clock phase value to write.
    input  wire       ctrl_rx_irq_en_i,      // Receive interrupt enable to write.
    input  wire       scr_wr_i,              // Status/control register write strobe.
    input  wire       scr_fault_en_i,        // Fault detect enable to write.
    input  wire       scr_err_irq_en_i,      // Error interrupt enable to write.
    input  wire [1:0] scr_rate_i,            // Rate select field to write.
    input  wire       scr_rd_i,              // Status/control register read strobe.
    input  wire       data_wr_i,             // Data register write strobe.
    input  wire [7:0] data_wdata_i,          // Byte written to the transmit buffer.
    input  wire       data_rd_i,             // Data register read strobe.
    input  wire       sck_i,                 // Serial clock pin, input side.
    output reg        sck_o,                 // Serial clock pin, output side.
    output reg        sck_oe_o,              // Serial clock pin drive enable.
    input  wire       mosi_i,                // Master-out pin, input side.
    output wire       mosi_o,                // Master-out pin, output side.
    output reg        mosi_oe_o,             // Master-out pin drive enable.
    input  wire       miso_i,                // Master-in pin, input side.
    output wire       miso_o,                // Master-in pin, output side.
    output reg        miso_oe_o,             // Master-in pin drive enable.
    input  wire       ss_n_i,                // Slave select pin, active low.
    output reg  [7:0] rx_data_o,             // Receive data register.
    output reg        tx_empty_flag_o,       // Transmit buffer empty.
    output reg        rx_full_flag_o,        // Receive register holds unread data.
    output reg        overrun_flag_o,        // A received byte was lost.
    output reg        select_fault_flag_o,   // Select pin disagreed with mode.
    output reg        module_enable_bit_o,   // Module enable readback.
    output reg        master_select_bit_o,   // Master select readback.
    output reg        irq_o                  // Shared receiver/error request.
);

    // Configuration held in the control registers.
    reg        cpol;                 // Idle level of the serial clock.
    reg        clock_phase_bit;                 // Clock phase.
    reg        rx_irq_en;            // Receive full may raise the request.
    reg        fault_detect_enable;  // Select faults may be flagged.
    reg        error_irq_enable;     // Overrun and fault may raise the request.
    reg  [1:0] rate_select_field;    // Master bit-rate divisor.

    // Transfer state.
    reg  [7:0] tx_buf;               // Queued transmit byte.
    reg  [7:0] shifter;              // Shift register, MSB on the wire.
    reg        samp;                 // Bit captured on the capture edge.
    reg  [3:0] edge_cnt;             // State counter: clock edges in transfer.
    reg        busy;                 // A transfer is in progress.
    reg        sck_act;              // Master clock sits at its active level.

    // Two-stage synchronisers plus a third stage for edge detection.
    reg        ss_s1, ss_s2, ss_s3;  // Slave select.
    reg        sck_s1, sck_s2, sck_s3; // Incoming serial clock.
    reg        mosi_s1, mosi_s2;     // Slave data in.
    reg        miso_s1, miso_s2;     // Master data in.

    // Arming bits of the two-step flag clearing sequences.
    reg        rx_arm;               // Status read seen with receive full.
    reg        ovr_arm;              // Status read seen with overrun.
    reg        fault_arm;            // Status read seen with select fault.

    wire       tick;                 // Half-bit tick of the master clock.

    // The bit clock only runs in enabled master mode, saving power.
    spq_clkdiv u_div (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .run_i     (module_enable_bit_o & master_select_bit_o),
        .rate_i    (rate_select_field),
        .tick_o    (tick)
    );

    // Pin synchronisers; the first stage feeds only the second.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            ss_s1   <= 1'b1;
            ss_s2   <= 1'b1;
            ss_s3   <= 1'b1;
            sck_s1  <= 1'b0;
            sck_s2  <= 1'b0;
            sck_s3  <= 1'b0;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            ss_s1   <= ss_n_i;
            ss_s2   <= ss_s1;
            ss_s3   <= ss_s2;
            sck_s1  <= sck_i;
            sck_s2  <= sck_s1;
            sck_s3  <= sck_s2;
            mosi_s1 <= mosi_i;
            mosi_s2 <= mosi_s1;
            miso_s1 <= miso_i;
            miso_s2 <= miso_s1;
        end
    end

    // Decoded conditions of the current cycle.
    wire enable    = module_enable_bit_o;
    wire master    = master_select_bit_o;
    wire slave_on  = enable & ~master;
    wire buf_full  = ~tx_empty_flag_o;
    wire ss_low    = ~ss_s2;
    wire ss_fall   = ~ss_s2 & ss_s3;
    wire ss_rise   = ss_s2 & ~ss_s3;
    wire s_lead    = (sck_s2 != cpol) & (sck_s3 == cpol);
    wire s_trail   = (sck_s2 == cpol) & (sck_s3 != cpol);
    // Master samples the master-in pin, a slave the master-out pin.
    wire din       = master ? miso_s2 : mosi_s2;

    // Phase 0 slave starts on select falling; phase 1 on first lead edge.
    wire s_start0  = slave_on & ~clock_phase_bit & ~busy & ss_fall;
    wire s_start1  = slave_on & clock_phase_bit & ~busy & ss_low & s_lead;
    // A deselected slave sees no clock edges at all.
    wire s_edge    = ss_low & (s_start1 | (busy & (s_lead | s_trail)));
    wire ev        = enable & (master ? (tick & busy) : s_edge);

    wire lead      = ~edge_cnt[0];
    wire last      = (edge_cnt == `SPQ_EDGE_LAST);
    // Phase 0 captures on leading edges, phase 1 on trailing edges.
    wire capture   = ev & (lead ^ clock_phase_bit);
    wire shift     = ev & ~capture & ~last & ~(clock_phase_bit & (edge_cnt == `SPQ_EDGE_ZERO));
    wire done      = ev & last;
    wire [7:0] done_byte = {shifter[6:0], clock_phase_bit ? din : samp};

    // A write in the same cycle defers the load, so the write is never lost.
    wire load_m    = enable & master & buf_full & ~data_wr_i & ((tick & ~busy) | done);
    wire load_s    = slave_on & ~busy & buf_full & ~data_wr_i;
    wire load      = load_m | load_s;

    // Overrun is checked at the seventh capture of the following byte.
    wire ovr_set   = capture & (edge_cnt[3:1] == `SPQ_OVR_CAPTURE) & rx_full_flag_o;
    wire rx_set    = done & ~overrun_flag_o & ~ovr_set;

    // Select faults: master sees select falling, busy slave sees it rise.
    wire m_fault   = enable & master & fault_detect_enable & ss_fall;
    wire s_abort   = slave_on & busy & ss_rise;
    wire s_fault   = s_abort & fault_detect_enable;
    wire fault_set = m_fault | s_fault;
    wire fault_now = enable & (master ? ss_low : (busy & ss_s2));

    // Configuration registers; a system reset clears them all, a master fault clears the enable.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            module_enable_bit_o <= 1'b0;
            master_select_bit_o <= 1'b0;
            cpol                <= 1'b0;
            clock_phase_bit                <= 1'b0;
            rx_irq_en           <= 1'b0;
            fault_detect_enable <= 1'b0;
            error_irq_enable    <= 1'b0;
            rate_select_field   <= `SPQ_RATE_DIV2;
        end else begin
            if (ctrl_wr_i) begin
                master_select_bit_o <= ctrl_master_i;
                cpol                <= ctrl_cpol_i;
                clock_phase_bit                <= ctrl_clock_phase_bit_i;
                rx_irq_en           <= ctrl_rx_irq_en_i;
            end
            // A master fault wins over an enable write; the fault leaves the master bit as it is.
            if (m_fault) begin
                module_enable_bit_o <= 1'b0;
            end else if (ctrl_wr_i) begin
                module_enable_bit_o <= ctrl_enable_i;
            end
            if (scr_wr_i) begin
                fault_detect_enable <= scr_fault_en_i;
                error_irq_enable    <= scr_err_irq_en_i;
                rate_select_field   <= scr_rate_i;
            end
        end
    end

    // Transfer engine; disabling or a master fault is a partial reset.
    always @(posedge ref_clk_i) begin
        if (reset_i || !enable || m_fault) begin
            shifter         <= `SPQ_BYTE_ZERO;
            samp            <= 1'b0;
            edge_cnt        <= `SPQ_EDGE_ZERO;
            busy            <= 1'b0;
            sck_act         <= 1'b0;
            tx_empty_flag_o <= 1'b1;
        end else begin
            // Loading beats completion; otherwise the last byte stays put.
            if (load) begin
                shifter <= tx_buf;
            end else if (done) begin
                shifter <= done_byte;
            end else if (shift) begin
                shifter <= {shifter[6:0], samp};
            end
            if (capture) begin
                samp <= din;
            end
            // A slave abort on deselect returns the counter to its start.
            if (s_abort) begin
                edge_cnt <= `SPQ_EDGE_ZERO;
            end else if (ev) begin
                edge_cnt <= last ? `SPQ_EDGE_ZERO : edge_cnt + `SPQ_EDGE_STEP;
            end
            // Busy spans from start to the last edge, or past it on a queue.
            if (s_abort) begin
                busy <= 1'b0;
            end else if (load_m | s_start0 | s_start1) begin
                busy <= 1'b1;
            end else if (done) begin
                busy <= 1'b0;
            end
            // Phase 0 leaves the clock idle until the first tick after the load.
            if (master && ev) begin
                sck_act <= lead;
            end
            // Moving the buffer sets the flag; only a data write clears it.
            if (load) begin
                tx_empty_flag_o <= 1'b1;
            end else if (data_wr_i) begin
                tx_empty_flag_o <= 1'b0;
            end
        end
    end

    // Transmit buffer; a write while full overwrites the queued byte.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_buf <= `SPQ_BYTE_ZERO;
        end else if (data_wr_i && enable) begin
            tx_buf <= data_wdata_i;
        end
    end

    // Receive register and its flags; a new set wins over a clear.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_data_o           <= `SPQ_BYTE_ZERO;
            rx_full_flag_o      <= 1'b0;
            overrun_flag_o      <= 1'b0;
            select_fault_flag_o <= 1'b0;
            rx_arm              <= 1'b0;
            ovr_arm             <= 1'b0;
            fault_arm           <= 1'b0;
        end else begin
            if (rx_set) begin
                rx_data_o <= done_byte;
            end
            // Receive full clears on status read then data read.
            if (rx_set) begin
                rx_full_flag_o <= 1'b1;
            end else if (data_rd_i && rx_arm) begin
                rx_full_flag_o <= 1'b0;
            end
            // Overrun clears on status read then data read.
            if (ovr_set) begin
                overrun_flag_o <= 1'b1;
            end else if (data_rd_i && ovr_arm) begin
                overrun_flag_o <= 1'b0;
            end
            // Fault clears on status read then control write, fault gone.
            if (fault_set) begin
                select_fault_flag_o <= 1'b1;
            end else if (ctrl_wr_i && fault_arm && !fault_now) begin
                select_fault_flag_o <= 1'b0;
            end
            // Arming bits follow status reads; the second step disarms.
            if (scr_rd_i) begin
                rx_arm <= rx_full_flag_o;
            end else if (data_rd_i) begin
                rx_arm <= 1'b0;
            end
            if (scr_rd_i) begin
                ovr_arm <= overrun_flag_o;
            end else if (data_rd_i) begin
                ovr_arm <= 1'b0;
            end
            // A fault seen during the sequence spoils it.
            if (scr_rd_i) begin
                fault_arm <= select_fault_flag_o & ~fault_now;
            end else if (ctrl_wr_i || fault_now) begin
                fault_arm <= 1'b0;
            end
        end
    end

    // Pin drivers, registered; the synchronised select adds a small lag.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            sck_o     <= 1'b0;
            sck_oe_o  <= 1'b0;
            mosi_oe_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            sck_o     <= cpol ^ sck_act;
            // A fault in either mode releases drivers to the port logic.
            sck_oe_o  <= enable & master & ~m_fault;
            mosi_oe_o <= enable & master & ~m_fault;
            miso_oe_o <= slave_on & ss_low;
        end
    end

    // The wire always carries the shift register MSB.
    assign mosi_o = shifter[7];
    assign miso_o = shifter[7];

    // Receive full, overrun and fault share one request line.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (rx_irq_en & rx_full_flag_o) |
                     (error_irq_enable & (overrun_flag_o | select_fault_flag_o));
        end
    end

    // Note: pin inputs lag two bus cycles, so the fastest divisor leaves
    // the master sampling one bus cycle late; use it only on short links.

endmodule

// ==== tb/spq_core_sva.sv ====
// Concurrent checks on the ports of the serial port core.
`timescale 1ns/1ns
module spq_core_sva (
    input wire       ref_clk_i,
    input wire       reset_i,
    input wire       scr_wr_i,
    input wire       scr_fault_en_i,
    input wire       scr_err_irq_en_i,
    input wire       data_wr_i,
    input wire       ss_n_i,
    input wire       sck_oe_o,
    input wire       mosi_oe_o,
    input wire       miso_oe_o,
    input wire [7:0] rx_data_o,
    input wire       tx_empty_flag_o,
    input wire       rx_full_flag_o,
    input wire       overrun_flag_o,
    input wire       select_fault_flag_o,
    input wire       module_enable_bit_o,
    input wire       master_select_bit_o,
    input wire       irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    reg fen;  // Mirror of the fault detect enable.
    reg eie;  // Mirror of the error interrupt enable.
    // The enables are not ports, so they are rebuilt from the write strobes.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            fen <= 1'b0;
            eie <= 1'b0;
        end else if (scr_wr_i) begin
            fen <= scr_fault_en_i;
            eie <= scr_err_irq_en_i;
        end
    end
    a_empty_only_write: assert property ($fell(tx_empty_flag_o) |-> $past(data_wr_i))
        else $error("transmit empty fell without a data write");
    a_write_clears_empty: assert property (data_wr_i && module_enable_bit_o |=> !tx_empty_flag_o)
        else $error("data write left transmit empty set");
    a_overrun_needs_full: assert property ($rose(overrun_flag_o) |-> $past(rx_full_flag_o))
        else $error("overrun set while receive register was read");
    a_overrun_holds_rx: assert property (overrun_flag_o [*2] |-> !$rose(rx_full_flag_o) && $stable(rx_data_o))
        else $error("byte moved during overrun");
    a_fault_needs_en: assert property ($rose(select_fault_flag_o) |-> $past(fen))
        else $error("select fault set with detect off");
    a_master_fault_off: assert property ($rose(select_fault_flag_o) && master_select_bit_o
        |-> !module_enable_bit_o && tx_empty_flag_o)
        else $error("master fault did not disable the unit");
    a_slave_fault_keeps: assert property ($rose(select_fault_flag_o) && !master_select_bit_o
        |-> module_enable_bit_o)
        else $error("slave fault cleared the enable");
    a_err_irq_shared: assert property (eie && (overrun_flag_o || select_fault_flag_o) |=> irq_o)
        else $error("error flag raised no request");
    a_disabled_pins_off: assert property (!module_enable_bit_o [*2] |-> !sck_oe_o && !mosi_oe_o && !miso_oe_o)
        else $error("pin driven while disabled");
    a_slave_miso_hiz: assert property (ss_n_i [*5] |-> !miso_oe_o)
        else $error("data out driven while deselected");
    c_overrun: cover property ($rose(overrun_flag_o));
    c_master_fault: cover property ($rose(select_fault_flag_o) && master_select_bit_o);
    c_slave_fault: cover property ($rose(select_fault_flag_o) && !master_select_bit_o);
endmodule
bind spq_core spq_core_sva u_sva (.ref_clk_i, .reset_i, .scr_wr_i, .scr_fault_en_i,
    .scr_err_irq_en_i, .data_wr_i, .ss_n_i, .sck_oe_o, .mosi_oe_o, .miso_oe_o, .rx_data_o,
    .tx_empty_flag_o, .rx_full_flag_o, .overrun_flag_o, .select_fault_flag_o,
    .module_enable_bit_o, .master_select_bit_o, .irq_o);

// ==== tb/spq_partner.sv ====
// Behavioural far-end serial slave used while the core is master.
`timescale 1ns/1ns
module spq_partner (
    input  wire        sck_i,    // Serial clock from the master.
    input  wire        mosi_i,   // Data from the master.
    input  wire        sel_n_i,  // Select, active low.
    input  wire  [7:0] tx_i,     // Byte to return.
    output wire        miso_o,   // Data back to the master.
    output logic [7:0] rx_o      // Byte captured from the master.
);
    logic [7:0] shreg = 8'h00;   // Outgoing shift register.
    logic       bit_in = 1'b0;   // Bit held between capture and shift.
    // A released line shows the inverse of its last level, so a stale read is caught.
    assign miso_o = sel_n_i ? ~shreg[7] : shreg[7];
    // Selection loads the byte so its first bit leads the first clock edge.
    always @(negedge sel_n_i) shreg = tx_i;
    // Leading edge captures, most significant bit first.
    always @(posedge sck_i) if (!sel_n_i) begin
        bit_in = mosi_i;
        rx_o = {rx_o[6:0], mosi_i};
    end
    // Trailing edge puts the next bit out.
    always @(negedge sck_i) if (!sel_n_i) shreg = {shreg[6:0], bit_in};
endmodule

// ==== tb/spq_core_bench.sv ====
// Self-checking bench for the serial port queue and fault logic.
`timescale 1ns/1ns
module spq_core_bench;
    logic ref_clk_i, reset_i, ctrl_wr_i, ctrl_enable_i, ctrl_master_i, ctrl_clock_phase_bit_i, ps;
    logic scr_wr_i, scr_fault_en_i, scr_err_irq_en_i, scr_rd_i, data_wr_i, data_rd_i;
    logic [1:0] scr_rate_i;
    logic [7:0] data_wdata_i, p_tx;
    logic ss_n_i, p_sel_n, tb_sck;
    wire sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, p_miso, irq_o;
    wire tx_empty_flag_o, rx_full_flag_o, overrun_flag_o, select_fault_flag_o;
    wire module_enable_bit_o, master_select_bit_o;
    wire [7:0] rx_data_o, p_rx;
    // Each pin carries the level of whichever party has its driver on.
    wire sck_i = sck_oe_o ? sck_o : tb_sck;
    wire mosi_i = mosi_oe_o ? mosi_o : 1'b0;
    wire miso_i = miso_oe_o ? miso_o : p_miso;
    int err_total, checked, n, k, mx;
    spq_core dut (.ref_clk_i, .reset_i, .ctrl_wr_i, .ctrl_enable_i, .ctrl_master_i,
        .ctrl_cpol_i(1'b0), .ctrl_clock_phase_bit_i, .ctrl_rx_irq_en_i(1'b0), .scr_wr_i, .scr_fault_en_i,
        .scr_err_irq_en_i, .scr_rate_i, .scr_rd_i, .data_wr_i, .data_wdata_i, .data_rd_i,
        .sck_i, .sck_o, .sck_oe_o, .mosi_i, .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o,
        .ss_n_i, .rx_data_o, .tx_empty_flag_o, .rx_full_flag_o, .overrun_flag_o,
        .select_fault_flag_o, .module_enable_bit_o, .master_select_bit_o, .irq_o);
    spq_partner u_partner (.sck_i(sck_i), .mosi_i(mosi_i), .sel_n_i(p_sel_n), .tx_i(p_tx),
        .miso_o(p_miso), .rx_o(p_rx));
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk1(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge ref_clk_i);
    endtask
    // Each strobe stands for exactly one rising edge.
    task automatic ctrl(input logic e, input logic m, input logic p);
        cyc(1);
        {ctrl_wr_i, ctrl_enable_i, ctrl_master_i, ctrl_clock_phase_bit_i} = {1'b1, e, m, p};
        cyc(1);
        ctrl_wr_i = 1'b0;
    endtask
    task automatic scr(input logic f, input logic ie, input logic [1:0] r);
        cyc(1);
        {scr_wr_i, scr_fault_en_i, scr_err_irq_en_i, scr_rate_i} = {1'b1, f, ie, r};
        cyc(1);
        scr_wr_i = 1'b0;
    endtask
    task automatic wr(input logic [7:0] b);
        cyc(1);
        {data_wr_i, data_wdata_i} = {1'b1, b};
        cyc(1);
        data_wr_i = 1'b0;
    endtask
    // A status read when d is low, a data read when d is high.
    task automatic rd(input logic d);
        cyc(1);
        {data_rd_i, scr_rd_i} = {d, ~d};
        cyc(1);
        {data_rd_i, scr_rd_i} = 2'h0;
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // The whole run needs under a thousand cycles, so this bound means a hang.
    initial begin
        #160000;
        err_total++;
        $display("MISMATCH watchdog expected end seen hang");
        print_verdict();
    end
    initial begin
        {ctrl_wr_i, ctrl_enable_i, ctrl_master_i, ctrl_clock_phase_bit_i, scr_wr_i, scr_fault_en_i} = 6'h00;
        {scr_err_irq_en_i, scr_rd_i, data_wr_i, data_rd_i, scr_rate_i, tb_sck} = 7'h00;
        {ss_n_i, p_sel_n, reset_i, data_wdata_i, p_tx} = {3'h7, 8'h00, 8'hA5};
        err_total = 0;
        checked = 0;
        cyc(16);
        reset_i = 1'b0;
        chk1("tx_empty", 1'b1, tx_empty_flag_o);
        chk1("sck_oe", 1'b0, sck_oe_o);
        $display("test reset done");
        scr(1'b1, 1'b1, 2'h1);
        ctrl(1'b1, 1'b1, 1'b0);
        p_sel_n = 1'b0;
        cyc(1);
        chk1("miso_oe", 1'b0, miso_oe_o);
        chk1("mosi_oe", 1'b1, mosi_oe_o);
        wr(8'h3C);
        chk1("tx_empty", 1'b0, tx_empty_flag_o);
        for (n = 0; n < 20 && tx_empty_flag_o !== 1'b1; n++) cyc(1);
        chk1("start_delay", 1'b1, n < 8);
        wr(8'hC3);
        for (n = 0; n < 200 && rx_full_flag_o !== 1'b1; n++) cyc(1);
        chk8("rx_data", 8'hA5, rx_data_o);
        chk8("far_rx", 8'h3C, p_rx);
        ps = sck_o;
        {k, mx} = 0;
        // Queued byte follows at once, so the clock never rests a full bit.
        repeat (20) begin
            cyc(1);
            k = (sck_o === ps) ? k + 1 : 0;
            ps = sck_o;
            mx = (k > mx) ? k : mx;
        end
        chk1("no_gap", 1'b1, mx < 6);
        for (n = 0; n < 100 && overrun_flag_o !== 1'b1; n++) cyc(1);
        chk1("overrun", 1'b1, overrun_flag_o);
        cyc(40);
        chk8("rx_kept", 8'hA5, rx_data_o);
        chk8("far_rx2", 8'hC3, p_rx);
        chk1("irq", 1'b1, irq_o);
        rd(1'b0);
        rd(1'b1);
        chk1("overrun", 1'b0, overrun_flag_o);
        chk1("rx_full", 1'b0, rx_full_flag_o);
        $display("test master queue done");
        ss_n_i = 1'b0;
        cyc(8);
        chk1("fault", 1'b1, select_fault_flag_o);
        chk1("enable", 1'b0, module_enable_bit_o);
        chk1("tx_empty", 1'b1, tx_empty_flag_o);
        chk1("master", 1'b1, master_select_bit_o);
        chk1("sck_oe", 1'b0, sck_oe_o);
        {ss_n_i, p_sel_n} = 2'h3;
        cyc(4);
        rd(1'b0);
        ctrl(1'b0, 1'b1, 1'b0);
        chk1("fault", 1'b0, select_fault_flag_o);
        $display("test master fault done");
        ctrl(1'b1, 1'b0, 1'b0);
        ss_n_i = 1'b0;
        cyc(6);
        chk1("miso_oe", 1'b1, miso_oe_o);
        ss_n_i = 1'b1;
        cyc(6);
        chk1("fault", 1'b1, select_fault_flag_o);
        chk1("enable", 1'b1, module_enable_bit_o);
        chk1("miso_oe", 1'b0, miso_oe_o);
        rd(1'b0);
        ctrl(1'b1, 1'b0, 1'b1);
        chk1("fault", 1'b0, select_fault_flag_o);
        ss_n_i = 1'b0;
        cyc(6);
        ss_n_i = 1'b1;
        cyc(6);
        chk1("fault", 1'b0, select_fault_flag_o);
        // Phase 1 slave byte clocked by the bench; the master side samples on trailing edges.
        wr(8'h96);
        ss_n_i = 1'b0;
        cyc(2);
        chk1("tx_empty", 1'b1, tx_empty_flag_o);
        for (n = 0; n < 16; n++) begin
            cyc(4);
            if (n[0]) k = {k[6:0], miso_o};
            tb_sck = ~tb_sck;
        end
        cyc(4);
        ss_n_i = 1'b1;
        chk8("slave_out", 8'h96, k[7:0]);
        chk8("slave_in", 8'h00, rx_data_o);
        cyc(6);
        chk1("fault", 1'b0, select_fault_flag_o);
        scr(1'b0, 1'b1, 2'h3);
        ctrl(1'b1, 1'b1, 1'b0);
        ss_n_i = 1'b0;
        cyc(8);
        chk1("fault", 1'b0, select_fault_flag_o);
        ss_n_i = 1'b1;
        $display("test slave and detect done");
        print_verdict();
    end
endmodule
